// file: ltc_defines.vh
/*
  Constants for the logic timer/counter unit: operation codes, preset
  field positions, time-base codes and tick counts.
  Assumes a 20 MHz core clock; included by the design files.
*/
`ifndef LTC_DEFINES_VH
`define LTC_DEFINES_VH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define LTC_OP_NONE      4'h0
`define LTC_OP_PULSE     4'h1
`define LTC_OP_EXT_PULSE 4'h2
`define LTC_OP_ON_DELAY  4'h3
`define LTC_OP_STORED_ON 4'h4
`define LTC_OP_OFF_DELAY 4'h5
`define LTC_OP_T_RESET   4'h6
`define LTC_OP_C_SET     4'h7
`define LTC_OP_C_RESET   4'h8
`define LTC_OP_C_UP      4'h9
`define LTC_OP_C_DOWN    4'hA
`define LTC_OP_READ      4'hB

// ----------------------------------------------------------------
// Preset fields
// ----------------------------------------------------------------
`define LTC_TVAL_MSB     11
`define LTC_TBASE_LSB    12
`define LTC_TBASE_MSB    13
`define LTC_CVAL_MSB     11

// ----------------------------------------------------------------
// Time bases and tick timing
// ----------------------------------------------------------------
`define LTC_TB_10MS      2'h0
`define LTC_TB_100MS     2'h1
`define LTC_TB_1S        2'h2
`define LTC_TB_10S       2'h3
`define LTC_CLK_HZ       20000000
`define LTC_BASE_TICK_HZ 100
`define LTC_BASE_TICK_CYC (`LTC_CLK_HZ / `LTC_BASE_TICK_HZ)
`define LTC_DIV_STEP     10

`endif

// file: ltc_props.sv
/* Checker for read answers and value forms of ltc_unit.
   Assumes only the ports of ltc_unit. */
`timescale 1ns/1ns
`include "ltc_defines.vh"
module ltc_props #(
  parameter IDX_W = 3
) (
  input wire             core_clk,
  input wire             nrst,
  input wire             op_valid,
  input wire [3:0]       op_code,
  input wire             op_is_counter,
  input wire [IDX_W-1:0] op_index,
  input wire             logic_result_bit,
  input wire [15:0]      primary_accumulator,
  input wire             status_ff,
  input wire [15:0]      value_bin_ff,
  input wire [15:0]      value_bcd_ff,
  input wire             answer_valid_ff
);
  // ------------------------------
  // Properties
  // ------------------------------
  wire       rd = op_valid && op_code == `LTC_OP_READ;
  wire [3:0] d2 = value_bcd_ff[11:8];
  wire [3:0] d1 = value_bcd_ff[7:4];
  wire [3:0] d0 = value_bcd_ff[3:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd;
    rd;
  endsequence
  sequence s_crd;
    rd && op_is_counter;
  endsequence
  read_answer_a: assert property (s_rd |=> answer_valid_ff)
    else $error("read got no answer");
  answer_cause_a: assert property (answer_valid_ff |-> $past(rd))
    else $error("answer without read");
  answer_pulse_a: assert property (s_rd ##1 !rd |=> !answer_valid_ff)
    else $error("answer longer than one cycle");
  value_hold_a: assert property (!answer_valid_ff && $past(nrst) |->
    $stable(status_ff) && $stable(value_bin_ff) && $stable(value_bcd_ff))
    else $error("value changed without read");
  cnt_range_a: assert property (s_crd |=> value_bin_ff <= 16'h03E7)
    else $error("count above range");
  cnt_digits_a: assert property (s_crd |=> value_bcd_ff[15:12] == 4'h0 &&
    d2 <= 4'h9 && d1 <= 4'h9 && d0 <= 4'h9) else $error("count digits not decimal");
  cnt_forms_a: assert property (s_crd |=>
    value_bin_ff == d2 * 16'h0064 + d1 * 16'h000A + d0) else $error("forms disagree");
  cnt_status_a: assert property (s_crd |=> status_ff == (value_bin_ff != 16'h0000))
    else $error("counter status wrong");
  tmr_top_a: assert property (s_rd ##0 !op_is_counter |=> value_bcd_ff[15:14] == 2'h0)
    else $error("timer top bits set");
endmodule // ltc_props
bind ltc_unit ltc_props #(.IDX_W(IDX_W)) u_props (.*);

// file: ltc_seq_model.sv
/* Scanning sequencer model: issues one operation per call.
   Assumes the bench calls issue from one process. */
`timescale 1ns/1ns
module ltc_seq_model #(
  parameter IDX_W = 3
) (
  input  wire             core_clk,
  output reg              op_valid,
  output reg  [3:0]       op_code,
  output reg              op_is_counter,
  output reg  [IDX_W-1:0] op_index,
  output reg              logic_result_bit,
  output reg  [15:0]      primary_accumulator
);
  // ------------------------------
  // Operation issue
  // ------------------------------
  initial begin
    {op_valid, op_code, op_is_counter, op_index, logic_result_bit} = 0;
    primary_accumulator = 16'h0000;
  end
  // Presets come in BCD; qualifiers scrambled once released
  task issue(input [3:0] c, input k, input [IDX_W-1:0] i, input r, input [15:0] a);
    begin
      @(posedge core_clk);
      #1;
      {op_valid, op_code, op_is_counter, op_index, logic_result_bit} = {1'b1, c, k, i, r};
      primary_accumulator = a;
      @(posedge core_clk);
      #1;
      {op_valid, op_code, op_is_counter, op_index, logic_result_bit} = {1'b0, ~c, ~k, ~i, ~r};
      primary_accumulator = ~a;
    end
  endtask
endmodule // ltc_seq_model

// file: ltc_tick_gen.v
/*
  Time-base tick generator: 10 ms base tick and divided 100 ms, 1 s,
  10 s ticks, each a one-cycle pulse.
  Assumes a free-running core clock at the rate in the header.
*/
`timescale 1ns/1ns
`include "ltc_defines.vh"

module ltc_tick_gen #(
  parameter BASE_CYC = `LTC_BASE_TICK_CYC
) (
  input  wire       core_clk,
  input  wire       nrst,
  output reg  [3:0] tick_ff
);

  reg [31:0] base_cnt_ff;
  reg [3:0]  d1_ff;
  reg [3:0]  d2_ff;
  reg [3:0]  d3_ff;
  wire       base_hit;

  assign base_hit = (base_cnt_ff == BASE_CYC - 1);

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      base_cnt_ff <= 32'h0;
      d1_ff       <= 4'h0;
      d2_ff       <= 4'h0;
      d3_ff       <= 4'h0;
      tick_ff     <= 4'h0;
    end else begin
      tick_ff <= 4'h0;
      if (base_hit) begin
        base_cnt_ff <= 32'h0;
        tick_ff[0]  <= 1'b1;
        d1_ff       <= (d1_ff == `LTC_DIV_STEP - 1) ? 4'h0 : d1_ff + 4'h1;
        if (d1_ff == `LTC_DIV_STEP - 1) begin
          tick_ff[1] <= 1'b1;
          d2_ff      <= (d2_ff == `LTC_DIV_STEP - 1) ? 4'h0 : d2_ff + 4'h1;
          if (d2_ff == `LTC_DIV_STEP - 1) begin
            tick_ff[2] <= 1'b1;
            d3_ff      <= (d3_ff == `LTC_DIV_STEP - 1) ? 4'h0 : d3_ff + 4'h1;
            if (d3_ff == `LTC_DIV_STEP - 1)
              tick_ff[3] <= 1'b1;
          end
        end
      end else begin
        base_cnt_ff <= base_cnt_ff + 32'h1;
      end
    end
  end

endmodule // ltc_tick_gen

// file: ltc_unit.v
/*
  Bank of timers and BCD up/down counters driven by scan operations.
  Assumes the sequencer issues one operation per cycle with op_valid,
  an index, the logic result bit and the primary accumulator word.
*/
`timescale 1ns/1ns
`include "ltc_defines.vh"

module ltc_unit #(
  parameter NUM_T    = 8,
  parameter NUM_C    = 8,
  parameter IDX_W    = 3,
  parameter BASE_CYC = `LTC_BASE_TICK_CYC
) (
  input  wire                core_clk,
  input  wire                nrst,
  input  wire                op_valid,
  input  wire [3:0]          op_code,
  input  wire                op_is_counter,
  input  wire [IDX_W-1:0]    op_index,
  input  wire                logic_result_bit,
  input  wire [15:0]         primary_accumulator,
  output reg                 status_ff,
  output reg  [15:0]         value_bin_ff,
  output reg  [15:0]         value_bcd_ff,
  output reg                 answer_valid_ff
);

  localparam ST_IDLE = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_DONE = 3'h4;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [11:0] t_init_ff  [0:NUM_T-1];
  reg [11:0] t_val_ff   [0:NUM_T-1];
  reg [1:0]  t_base_ff  [0:NUM_T-1];
  reg [2:0]  t_state_ff [0:NUM_T-1];
  reg [3:0]  t_mode_ff  [0:NUM_T-1];
  reg        t_in_ff    [0:NUM_T-1];
  reg        t_last_ff  [0:NUM_T-1];
  reg [11:0] c_val_ff   [0:NUM_C-1];
  reg        c_last_ff  [0:NUM_C-1];
  wire [3:0] tick;
  integer    i;
  integer    j;
  reg        rd_op;
  reg        nxt_status;
  reg [15:0] nxt_value_bin;
  reg [15:0] nxt_value_bcd;
  reg        nxt_answer_valid;

  ltc_tick_gen #(
    .BASE_CYC (BASE_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tick_ff  (tick)
  );

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [11:0] bcd_dec;
    input [11:0] v;
    begin
      if (v[3:0] != 4'h0)
        bcd_dec = {v[11:4], v[3:0] - 4'h1};
      else if (v[7:4] != 4'h0)
        bcd_dec = {v[11:8], v[7:4] - 4'h1, 4'h9};
      else if (v[11:8] != 4'h0)
        bcd_dec = {v[11:8] - 4'h1, 8'h99};
      else
        bcd_dec = 12'h000;
    end
  endfunction

  function [11:0] bcd_inc;
    input [11:0] v;
    begin
      if (v == 12'h999)
        bcd_inc = v;
      else if (v[3:0] != 4'h9)
        bcd_inc = {v[11:4], v[3:0] + 4'h1};
      else if (v[7:4] != 4'h9)
        bcd_inc = {v[11:8], v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[11:8] + 4'h1, 8'h00};
    end
  endfunction

  function [15:0] bcd_to_bin;
    input [11:0] v;
    begin
      bcd_to_bin = ({12'h000, v[11:8]} * 16'h0064)
                 + ({12'h000, v[7:4]} * 16'h000A)
                 + {12'h000, v[3:0]};
    end
  endfunction

  function [11:0] bcd_fix;
    input [11:0] v;
    begin
      bcd_fix[11:8] = (v[11:8] > 4'h9) ? 4'h9 : v[11:8];
      bcd_fix[7:4]  = (v[7:4] > 4'h9) ? 4'h9 : v[7:4];
      bcd_fix[3:0]  = (v[3:0] > 4'h9) ? 4'h9 : v[3:0];
    end
  endfunction

  function status_of;
    input [3:0] mode;
    input [2:0] state;
    input       level;
    begin
      case (mode)
        `LTC_OP_PULSE, `LTC_OP_EXT_PULSE:
          status_of = (state == ST_RUN);
        `LTC_OP_ON_DELAY:
          status_of = (state == ST_DONE) && level;
        `LTC_OP_STORED_ON:
          status_of = (state == ST_DONE);
        `LTC_OP_OFF_DELAY:
          status_of = level || (state == ST_RUN);
        default:
          status_of = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always @* begin
    rd_op            = op_valid && (op_code == `LTC_OP_READ);
    nxt_answer_valid = rd_op;
    nxt_status       = status_ff;
    nxt_value_bin    = value_bin_ff;
    nxt_value_bcd    = value_bcd_ff;
    if (rd_op) begin
      if (op_is_counter) begin
        nxt_status    = (c_val_ff[op_index] != 12'h000);
        nxt_value_bin = bcd_to_bin(c_val_ff[op_index]);
        nxt_value_bcd = {4'h0, c_val_ff[op_index]};
      end else begin
        nxt_status    = status_of(t_mode_ff[op_index], t_state_ff[op_index],
                                  t_in_ff[op_index]);
        nxt_value_bin = bcd_to_bin(t_val_ff[op_index]);
        nxt_value_bcd = {2'h0, t_base_ff[op_index], t_val_ff[op_index]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      for (i = 0; i < NUM_T; i = i + 1) begin
        t_init_ff[i]  <= 12'h000;
        t_val_ff[i]   <= 12'h000;
        t_base_ff[i]  <= `LTC_TB_10MS;
        t_state_ff[i] <= ST_IDLE;
        t_mode_ff[i]  <= `LTC_OP_NONE;
        t_in_ff[i]    <= 1'b0;
        t_last_ff[i]  <= 1'b0;
      end
    end else begin
      // Decrement per selected tick, only for timers in ST_RUN
      for (i = 0; i < NUM_T; i = i + 1) begin
        if (t_state_ff[i] == ST_RUN && tick[t_base_ff[i]]) begin
          if (t_val_ff[i] == 12'h001 || t_val_ff[i] == 12'h000) begin
            t_val_ff[i]   <= 12'h000;
            t_state_ff[i] <= ST_DONE;
          end else begin
            t_val_ff[i] <= bcd_dec(t_val_ff[i]);
          end
        end
      end
      if (op_valid && !op_is_counter && op_code != `LTC_OP_READ) begin
        t_last_ff[op_index] <= logic_result_bit;
        t_in_ff[op_index]   <= logic_result_bit;
        case (op_code)
          `LTC_OP_T_RESET: begin
            if (logic_result_bit) begin
              t_val_ff[op_index]   <= t_init_ff[op_index];
              t_state_ff[op_index] <= ST_IDLE;
            end
          end
          `LTC_OP_OFF_DELAY: begin
            t_mode_ff[op_index] <= op_code;
            if (logic_result_bit) begin
              t_init_ff[op_index]  <= bcd_fix(primary_accumulator[`LTC_TVAL_MSB:0]);
              t_base_ff[op_index]  <= primary_accumulator[`LTC_TBASE_MSB:`LTC_TBASE_LSB];
              t_val_ff[op_index]   <= bcd_fix(primary_accumulator[`LTC_TVAL_MSB:0]);
              t_state_ff[op_index] <= ST_IDLE;
            end else if (t_last_ff[op_index]) begin
              t_val_ff[op_index]   <= t_init_ff[op_index];
              t_state_ff[op_index] <= ST_RUN;
            end
          end
          `LTC_OP_PULSE, `LTC_OP_EXT_PULSE, `LTC_OP_ON_DELAY, `LTC_OP_STORED_ON: begin
            t_mode_ff[op_index] <= op_code;
            if (logic_result_bit && !t_last_ff[op_index]) begin
              t_init_ff[op_index]  <= bcd_fix(primary_accumulator[`LTC_TVAL_MSB:0]);
              t_base_ff[op_index]  <= primary_accumulator[`LTC_TBASE_MSB:`LTC_TBASE_LSB];
              t_val_ff[op_index]   <= bcd_fix(primary_accumulator[`LTC_TVAL_MSB:0]);
              t_state_ff[op_index] <= ST_RUN;
            end else if (!logic_result_bit &&
                         (op_code == `LTC_OP_PULSE || op_code == `LTC_OP_ON_DELAY)) begin
              t_val_ff[op_index]   <= 12'h000;
              t_state_ff[op_index] <= ST_IDLE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      for (j = 0; j < NUM_C; j = j + 1) begin
        c_val_ff[j]  <= 12'h000;
        c_last_ff[j] <= 1'b0;
      end
    end else begin
      if (op_valid && op_is_counter && op_code != `LTC_OP_READ) begin
        c_last_ff[op_index] <= logic_result_bit;
        case (op_code)
          `LTC_OP_C_SET: begin
            if (logic_result_bit && !c_last_ff[op_index])
              c_val_ff[op_index] <= bcd_fix(primary_accumulator[`LTC_CVAL_MSB:0]);
          end
          `LTC_OP_C_RESET: begin
            if (logic_result_bit)
              c_val_ff[op_index] <= 12'h000;
          end
          `LTC_OP_C_UP: begin
            if (logic_result_bit && !c_last_ff[op_index])
              c_val_ff[op_index] <= bcd_inc(c_val_ff[op_index]);
          end
          `LTC_OP_C_DOWN: begin
            if (logic_result_bit && !c_last_ff[op_index])
              c_val_ff[op_index] <= bcd_dec(c_val_ff[op_index]);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Answer registers
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      status_ff       <= 1'b0;
      value_bin_ff    <= 16'h0000;
      value_bcd_ff    <= 16'h0000;
      answer_valid_ff <= 1'b0;
    end else begin
      status_ff       <= nxt_status;
      value_bin_ff    <= nxt_value_bin;
      value_bcd_ff    <= nxt_value_bcd;
      answer_valid_ff <= nxt_answer_valid;
    end
  end

endmodule // ltc_unit

// file: tb_logic_timer_counter_unit.sv
/* Bench for ltc_unit: counter model checked at every counter read,
   timer status checked inside its tolerance. Uses ltc_seq_model. */
`timescale 1ns/1ns
`include "ltc_defines.vh"
module tb_logic_timer_counter_unit;
  reg         core_clk = 1'b0;
  reg         nrst = 1'b0;
  wire        op_valid, op_is_counter, logic_result_bit, status_ff, answer_valid_ff;
  wire [3:0]  op_code;
  wire [2:0]  op_index;
  wire [15:0] primary_accumulator, value_bin_ff, value_bcd_ff;
  integer     n_fail = 0, samples_checked = 0, seed = 72, b, t;
  integer     cnt [0:7];
  reg         last [0:7];
  reg  [15:0] a;
  always #25 core_clk = ~core_clk;
  ltc_seq_model #(.IDX_W(3)) u_seq (.*);
  ltc_unit #(.IDX_W(3), .BASE_CYC(4)) DUT (.*);
  // ------------------------------
  // Tasks
  // ------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task rd(input k, input [2:0] i);
    begin
      u_seq.issue(`LTC_OP_READ, k, i, 1'b0, 16'h0000);
      chk(answer_valid_ff, 1'b1);
    end
  endtask
  task tchk(input [2:0] i, input e);
    begin
      rd(1'b0, i);
      chk(status_ff, e);
    end
  endtask
  task top(input [3:0] c, input [2:0] i, input r, input [15:0] v);
    u_seq.issue(c, 1'b0, i, r, v);
  endtask
  task cop(input [3:0] c, input [2:0] i, input r, input [15:0] v);
    reg e;
    begin
      u_seq.issue(c, 1'b1, i, r, v);
      e = r && !last[i];
      if (c == `LTC_OP_C_SET && e) cnt[i] = v[11:8]*100+v[7:4]*10+v[3:0];
      if (c == `LTC_OP_C_RESET && r) cnt[i] = 0;
      if (c == `LTC_OP_C_UP && e && cnt[i] < 999) cnt[i] = cnt[i] + 1;
      if (c == `LTC_OP_C_DOWN && e && cnt[i] > 0) cnt[i] = cnt[i] - 1;
      last[i] = r;
      rd(1'b1, i);
      a = cnt[i];
      chk(status_ff, a != 0);
      chk(value_bin_ff, a);
      chk(value_bcd_ff, a / 100 * 256 + a / 10 % 10 * 16 + a % 10);
    end
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    for (b = 0; b < 8; b = b + 1) begin
      cnt[b] = 0;
      last[b] = 1'b0;
    end
    repeat (10) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    a = $random(seed);
    cop(`LTC_OP_C_SET, 0, 1, {a[15:12], 12'h998});
    for (b = 0; b < 4; b = b + 1) cop(`LTC_OP_C_UP, 0, b[0], 0);
    cop(`LTC_OP_C_RESET, 0, 1, 0);
    cop(`LTC_OP_C_UP, 0, 1, 0);
    for (b = 0; b < 4; b = b + 1) cop(`LTC_OP_C_DOWN, 0, b[0], 0);
    for (b = 0; b < 80; b = b + 1) begin
      a = $random(seed);
      t = $random(seed);
      cop(4'h7 + t[1:0], t[4:2], t[5], {a[15:12], a[11:8] % 4'hA, a[7:4] % 4'hA, a[3:0] % 4'hA});
    end
    for (b = 0; b < 4; b = b + 1) begin
      t = 4;
      repeat (b) t = t * 10;
      a = {2'h3, b[1:0], 12'h003};
      top(`LTC_OP_EXT_PULSE, b[2:0], 0, a);
      top(`LTC_OP_EXT_PULSE, b[2:0], 1, a);
      top(`LTC_OP_EXT_PULSE, b[2:0], 0, a);
      repeat (t / 2) @(posedge core_clk);
      tchk(b[2:0], 1);
      chk(value_bcd_ff[15:12], {2'h0, b[1:0]});
      repeat (4 * t) @(posedge core_clk);
      tchk(b[2:0], 0);
    end
    top(`LTC_OP_EXT_PULSE, 0, 1, 16'h0005);
    repeat (10) @(posedge core_clk);
    top(`LTC_OP_EXT_PULSE, 0, 0, 16'h0005);
    top(`LTC_OP_EXT_PULSE, 0, 1, 16'h0005);
    repeat (10) @(posedge core_clk);
    tchk(0, 1);
    top(`LTC_OP_PULSE, 4, 1, 16'h0005);
    tchk(4, 1);
    top(`LTC_OP_PULSE, 4, 0, 16'h0005);
    tchk(4, 0);
    top(`LTC_OP_PULSE, 4, 1, 16'h0005);
    repeat (40) @(posedge core_clk);
    tchk(4, 0);
    top(`LTC_OP_ON_DELAY, 5, 1, 16'h0003);
    tchk(5, 0);
    repeat (20) @(posedge core_clk);
    tchk(5, 1);
    top(`LTC_OP_ON_DELAY, 5, 0, 16'h0003);
    tchk(5, 0);
    top(`LTC_OP_STORED_ON, 6, 1, 16'h0003);
    top(`LTC_OP_STORED_ON, 6, 0, 16'h0003);
    repeat (20) @(posedge core_clk);
    tchk(6, 1);
    top(`LTC_OP_T_RESET, 6, 1, 16'h0003);
    tchk(6, 0);
    top(`LTC_OP_OFF_DELAY, 7, 1, 16'h0003);
    tchk(7, 1);
    top(`LTC_OP_OFF_DELAY, 7, 0, 16'h0003);
    tchk(7, 1);
    repeat (20) @(posedge core_clk);
    tchk(7, 0);
    tally_and_finish;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail = n_fail + 1;
    tally_and_finish;
  end
endmodule // tb_logic_timer_counter_unit
